// [logic/cbs_top.v]
// CAN transmit error counting, fault states and bit-time synchronisation
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "cbs_consts.vh"

// What this block does
// - Bit error in active flag adds 8
// - Dominant runs after flags add 8
// - Other transmit errors add 8
// - Success lowers nonzero count by one
// - Arbitration stuff error leaves count unchanged
// - Passive ack error, quiet flag: no add
// - Passive node ack errors never add
// - Idle falling edge hard-syncs bit timing
// - Bit: sync, prop, phase1, phase2
// - Propagation segment one to eight quanta
// - Phase segments one to eight quanta
// - Edge in prop/phase1 lengthens phase1
// - Edge in phase2 shortens phase2
// - One soft resync per bit
// - Sample at phase boundary, transmit after
// - Jump width is min(4, phase length)
// - Phase2 never below one quantum
// - Passive above 127, active below 128
// - Transmit overflow enters bus-off, drivers off
// - Bus-off recovery by selected mode
// - Leaving bus-off clears both counters
module cbs_top (
    input  wire        CLK_SYS,
    input  wire        RESET,
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [7:0]  WB_ADR_I,
    input  wire [3:0]  WB_SEL_I,
    input  wire [31:0] WB_DAT_I,
    output reg  [31:0] WB_DAT_O,
    output reg         WB_ACK_O,
    input  wire        CAN_RX,
    output reg         CAN_TX,
    output reg         CAN_TX_OE,
    input  wire        TX_BIT,
    input  wire        BUS_IDLE,
    input  wire        FRAME_RX,
    input  wire        EV_BIT_ERR_FLAG,
    input  wire        EV_TX_ERR,
    input  wire        ERR_IS_ACK,
    input  wire        ERR_STUFF_ARB,
    input  wire        PFLAG_DOM_SEEN,
    input  wire        EV_FLAG_END_ACT,
    input  wire        EV_FLAG_END_PAS,
    input  wire        EV_VALID,
    input  wire [7:0]  REC_VALUE,
    output reg         SAMPLE_PT,
    output reg         RX_BIT,
    output reg         TX_POINT,
    output reg  [7:0]  TEC_VALUE,
    output reg         ERR_PASSIVE,
    output reg         BUS_OFF,
    output reg         REC_CLEAR
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [3:0] jump_width;
        input [3:0] len;
        begin
            if (len < `CBS_RJW_MAX)
                jump_width = len;
            else
                jump_width = `CBS_RJW_MAX;
        end
    endfunction

    function [3:0] seg_len;
        input [2:0] setting;
        begin
            seg_len = {1'b0, setting} + 4'h1;
        end
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg  [5:0] psc_reg;
    reg  [2:0] prop_reg;
    reg  [2:0] ps1_reg;
    reg  [2:0] ps2_reg;
    reg        frs_reg;
    reg        rx_s1_reg;
    reg        rx_s2_reg;
    reg        rx_s3_reg;
    reg  [5:0] div_reg;
    reg  [1:0] seg_reg;
    reg  [3:0] cnt_reg;
    reg  [3:0] ext_reg;
    reg  [3:0] shr_reg;
    reg        resynced_reg;
    reg  [3:0] dom_cnt_reg;
    reg  [3:0] dom_lim_reg;
    reg        dom_arm_reg;
    reg  [3:0] run_reg;
    reg  [7:0] grp_reg;
    reg  [3:0] cur_len;
    reg  [3:0] ph2_len;
    wire [8:0] tec_sum;
    wire       tq_en;
    wire       fall;
    wire       hard_sync;
    wire       soft_ok;
    wire       seg_end;
    wire       dom_hit;
    wire       ack_exempt;
    wire       tec_inc;
    wire       tec_dec;
    wire       wr_cfg;
    wire       rx_sample;
    wire [3:0] rjw1;
    wire [3:0] rjw2;
    wire [3:0] ps2_full;

    assign tq_en    = (div_reg == psc_reg);
    assign fall     = rx_s3_reg & ~rx_s2_reg;
    assign rx_sample = rx_s2_reg;
    assign rjw1     = jump_width(seg_len(ps1_reg));
    assign rjw2     = jump_width(seg_len(ps2_reg));
    assign ps2_full = seg_len(ps2_reg);
    assign hard_sync = fall & BUS_IDLE;
    assign soft_ok  = fall & FRAME_RX & ~BUS_IDLE & ~resynced_reg;

    // ----------------------------------------
    // Segment lengths
    // ----------------------------------------
    always @* begin
        if (ps2_full > shr_reg + 4'h1)
            ph2_len = ps2_full - shr_reg;
        else
            ph2_len = 4'h1;
        case (seg_reg)
            `CBS_SEG_SYNC: cur_len = 4'h1;
            `CBS_SEG_PROP: cur_len = seg_len(prop_reg);
            `CBS_SEG_PH1:  cur_len = seg_len(ps1_reg) + ext_reg;
            `CBS_SEG_PH2:  cur_len = ph2_len;
            default:       cur_len = 4'h1;
        endcase
    end

    assign seg_end = tq_en & (cnt_reg + 4'h1 >= cur_len);

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_s3_reg <= 1'b1;
        end else begin
            rx_s1_reg <= CAN_RX;
            rx_s2_reg <= rx_s1_reg;
            rx_s3_reg <= rx_s2_reg;
        end
    end

    // ----------------------------------------
    // Quantum divider and bit segments
    // ----------------------------------------
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            div_reg      <= 6'h00;
            seg_reg      <= `CBS_SEG_SYNC;
            cnt_reg      <= 4'h0;
            ext_reg      <= 4'h0;
            shr_reg      <= 4'h0;
            resynced_reg <= 1'b0;
            SAMPLE_PT    <= 1'b0;
            RX_BIT       <= 1'b1;
            TX_POINT     <= 1'b0;
            CAN_TX       <= 1'b1;
            CAN_TX_OE    <= 1'b0;
        end else begin
            SAMPLE_PT <= 1'b0;
            TX_POINT  <= 1'b0;
            CAN_TX_OE <= ~BUS_OFF;
            if (BUS_OFF)
                CAN_TX <= 1'b1;
            if (hard_sync) begin
                div_reg      <= 6'h00;
                seg_reg      <= `CBS_SEG_SYNC;
                cnt_reg      <= 4'h0;
                ext_reg      <= 4'h0;
                shr_reg      <= 4'h0;
                resynced_reg <= 1'b1;
            end else begin
                if (tq_en)
                    div_reg <= 6'h00;
                else
                    div_reg <= div_reg + 6'h01;
                if (soft_ok && (seg_reg == `CBS_SEG_PROP || seg_reg == `CBS_SEG_PH1)) begin
                    ext_reg      <= rjw1;
                    resynced_reg <= 1'b1;
                end
                if (soft_ok && seg_reg == `CBS_SEG_PH2) begin
                    shr_reg      <= rjw2;
                    resynced_reg <= 1'b1;
                end
                if (seg_end) begin
                    cnt_reg <= 4'h0;
                    case (seg_reg)
                        `CBS_SEG_SYNC: seg_reg <= `CBS_SEG_PROP;
                        `CBS_SEG_PROP: seg_reg <= `CBS_SEG_PH1;
                        `CBS_SEG_PH1: begin
                            seg_reg   <= `CBS_SEG_PH2;
                            SAMPLE_PT <= 1'b1;
                            RX_BIT    <= rx_sample;
                        end
                        `CBS_SEG_PH2: begin
                            seg_reg      <= `CBS_SEG_SYNC;
                            ext_reg      <= 4'h0;
                            shr_reg      <= 4'h0;
                            resynced_reg <= 1'b0;
                            TX_POINT     <= 1'b1;
                            if (!BUS_OFF)
                                CAN_TX <= TX_BIT;
                        end
                        default: seg_reg <= `CBS_SEG_SYNC;
                    endcase
                end else if (tq_en) begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // Dominant runs after error flags
    // ----------------------------------------
    assign dom_hit = dom_arm_reg & SAMPLE_PT & ~RX_BIT & (dom_cnt_reg + 4'h1 == dom_lim_reg);

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            dom_arm_reg <= 1'b0;
            dom_cnt_reg <= 4'h0;
            dom_lim_reg <= `CBS_DOM_ACT;
        end else if (EV_FLAG_END_ACT || EV_FLAG_END_PAS) begin
            dom_arm_reg <= 1'b1;
            dom_cnt_reg <= 4'h0;
            dom_lim_reg <= EV_FLAG_END_ACT ? `CBS_DOM_ACT : `CBS_DOM_PAS;
        end else if (dom_arm_reg && SAMPLE_PT) begin
            if (RX_BIT) begin
                dom_arm_reg <= 1'b0;
            end else if (dom_hit) begin
                dom_cnt_reg <= 4'h0;
                dom_lim_reg <= `CBS_DOM_PAS;
            end else begin
                dom_cnt_reg <= dom_cnt_reg + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // Transmit error counter and fault states
    // ----------------------------------------
    assign ack_exempt = ERR_IS_ACK & ERR_PASSIVE & (~PFLAG_DOM_SEEN | ERR_PASSIVE);
    assign tec_inc = ~BUS_OFF & (EV_BIT_ERR_FLAG | dom_hit
                     | (EV_TX_ERR & ~ERR_STUFF_ARB & ~ack_exempt));
    assign tec_dec = ~BUS_OFF & EV_VALID & (TEC_VALUE != 8'h00);
    assign tec_sum = {1'b0, TEC_VALUE} + `CBS_TEC_STEP;

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            TEC_VALUE   <= 8'h00;
            ERR_PASSIVE <= 1'b0;
            BUS_OFF     <= 1'b0;
            REC_CLEAR   <= 1'b0;
            run_reg     <= 4'h0;
            grp_reg     <= 8'h00;
        end else begin
            REC_CLEAR <= 1'b0;
            if (tec_inc) begin
                if (tec_sum[8]) begin
                    TEC_VALUE <= 8'hff;
                    BUS_OFF   <= 1'b1;
                    run_reg   <= 4'h0;
                    grp_reg   <= 8'h00;
                end else begin
                    TEC_VALUE <= tec_sum[7:0];
                end
            end else if (tec_dec) begin
                TEC_VALUE <= TEC_VALUE - 8'h01;
            end
            if (BUS_OFF && SAMPLE_PT) begin
                if (RX_BIT) begin
                    if (run_reg + 4'h1 == `CBS_RCV_RUN) begin
                        run_reg <= 4'h0;
                        if (grp_reg == `CBS_RCV_GROUPS) begin
                            BUS_OFF   <= 1'b0;
                            TEC_VALUE <= 8'h00;
                            REC_CLEAR <= 1'b1;
                            grp_reg   <= 8'h00;
                        end else begin
                            grp_reg <= grp_reg + 8'h01;
                        end
                    end else begin
                        run_reg <= run_reg + 4'h1;
                    end
                end else if (frs_reg) begin
                    run_reg <= 4'h0;
                end
            end
            ERR_PASSIVE <= BUS_OFF | (TEC_VALUE > `CBS_PASSIVE_LIM) | (REC_VALUE > `CBS_PASSIVE_LIM);
        end
    end

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    assign wr_cfg = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O & (WB_ADR_I == `CBS_ADR_CFG);

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
            psc_reg  <= `CBS_PSC_RST;
            prop_reg <= `CBS_PROP_RST;
            ps1_reg  <= `CBS_PS1_RST;
            ps2_reg  <= `CBS_PS2_RST;
            frs_reg  <= `CBS_FRS_RST;
        end else begin
            WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
            WB_DAT_O <= 32'h00000000;
            if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
                case (WB_ADR_I)
                    `CBS_ADR_CFG: begin
                        WB_DAT_O[`CBS_PSC_LSB +: `CBS_PSC_W]  <= psc_reg;
                        WB_DAT_O[`CBS_PROP_LSB +: `CBS_SEG_W] <= prop_reg;
                        WB_DAT_O[`CBS_PS1_LSB +: `CBS_SEG_W]  <= ps1_reg;
                        WB_DAT_O[`CBS_PS2_LSB +: `CBS_SEG_W]  <= ps2_reg;
                        WB_DAT_O[`CBS_FRS_BIT]                <= frs_reg;
                    end
                    `CBS_ADR_STAT: begin
                        WB_DAT_O[`CBS_ST_TEC_LSB +: 8] <= TEC_VALUE;
                        WB_DAT_O[`CBS_ST_REC_LSB +: 8] <= REC_VALUE;
                        WB_DAT_O[`CBS_ST_PAS_BIT]      <= ERR_PASSIVE;
                        WB_DAT_O[`CBS_ST_BOFF_BIT]     <= BUS_OFF;
                        WB_DAT_O[`CBS_ST_SEG_LSB +: 2] <= seg_reg;
                    end
                    default: WB_DAT_O <= 32'h00000000;
                endcase
            end
            if (wr_cfg) begin
                if (WB_SEL_I[0])
                    psc_reg <= WB_DAT_I[`CBS_PSC_LSB +: `CBS_PSC_W];
                if (WB_SEL_I[1]) begin
                    prop_reg <= WB_DAT_I[`CBS_PROP_LSB +: `CBS_SEG_W];
                    ps1_reg  <= WB_DAT_I[`CBS_PS1_LSB +: `CBS_SEG_W];
                end
                if (WB_SEL_I[2])
                    ps2_reg <= WB_DAT_I[`CBS_PS2_LSB +: `CBS_SEG_W];
                if (WB_SEL_I[3])
                    frs_reg <= WB_DAT_I[`CBS_FRS_BIT];
            end
        end
    end

endmodule

// [include/cbs_consts.vh]
// Constants for the CAN error counter and bit timing block
`ifndef CBS_CONSTS_VH
`define CBS_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CBS_ADR_CFG       8'h00
`define CBS_ADR_STAT      8'h04

// ----------------------------------------
// Config field positions and reset values
// ----------------------------------------
`define CBS_PSC_LSB       0
`define CBS_PSC_W         6
`define CBS_PROP_LSB      8
`define CBS_PS1_LSB       12
`define CBS_PS2_LSB       16
`define CBS_SEG_W         3
`define CBS_FRS_BIT       24
`define CBS_PSC_RST       6'h00
`define CBS_PROP_RST      3'h1
`define CBS_PS1_RST       3'h3
`define CBS_PS2_RST       3'h3
`define CBS_FRS_RST       1'b0

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define CBS_ST_TEC_LSB    0
`define CBS_ST_REC_LSB    8
`define CBS_ST_PAS_BIT    16
`define CBS_ST_BOFF_BIT   17
`define CBS_ST_SEG_LSB    18

// ----------------------------------------
// Counting figures
// ----------------------------------------
`define CBS_TEC_STEP      9'h008
`define CBS_PASSIVE_LIM   8'h7f
`define CBS_DOM_ACT       4'he
`define CBS_DOM_PAS       4'h8
`define CBS_RJW_MAX       4'h4
`define CBS_RCV_RUN       4'hb
`define CBS_RCV_GROUPS    8'h7f

// ----------------------------------------
// Bit segment states
// ----------------------------------------
`define CBS_SEG_SYNC      2'h0
`define CBS_SEG_PROP      2'h1
`define CBS_SEG_PH1       2'h2
`define CBS_SEG_PH2       2'h3

`endif

// [tb/cbs_checker.sv]
// Port checker for the CAN error counter and bit timing block
`timescale 1ns/1ns
module cbs_checker (
    input wire       CLK_SYS,
    input wire       RESET,
    input wire       WB_ACK_O,
    input wire       CAN_TX,
    input wire       CAN_TX_OE,
    input wire       EV_BIT_ERR_FLAG,
    input wire       EV_TX_ERR,
    input wire       ERR_IS_ACK,
    input wire       ERR_STUFF_ARB,
    input wire       EV_VALID,
    input wire [7:0] REC_VALUE,
    input wire       SAMPLE_PT,
    input wire       RX_BIT,
    input wire       TX_POINT,
    input wire [7:0] TEC_VALUE,
    input wire       ERR_PASSIVE,
    input wire       BUS_OFF,
    input wire       REC_CLEAR
);
default clocking @(posedge CLK_SYS); endclocking
default disable iff (RESET);
wire inc = EV_BIT_ERR_FLAG | EV_TX_ERR;
property p_ack; WB_ACK_O |=> !WB_ACK_O; endproperty
a_ack: assert property (p_ack) else $error("ack longer than one cycle");
property p_bit_err;
    EV_BIT_ERR_FLAG && !BUS_OFF && TEC_VALUE < 8'hf8 |=> TEC_VALUE == $past(TEC_VALUE) + 8'h08;
endproperty
a_bit_err: assert property (p_bit_err) else $error("bit error step wrong");
property p_tx_err;
    EV_TX_ERR && !ERR_STUFF_ARB && !ERR_IS_ACK && !BUS_OFF && TEC_VALUE < 8'hf8
        |=> TEC_VALUE == $past(TEC_VALUE) + 8'h08;
endproperty
a_tx_err: assert property (p_tx_err) else $error("transmit error step wrong");
property p_dec;
    EV_VALID && !inc && !BUS_OFF && TEC_VALUE != 8'h00 |=> TEC_VALUE == $past(TEC_VALUE) - 8'h01;
endproperty
a_dec: assert property (p_dec) else $error("success did not lower count");
property p_arb; EV_TX_ERR && ERR_STUFF_ARB && !EV_BIT_ERR_FLAG && !EV_VALID |=> $stable(TEC_VALUE); endproperty
a_arb: assert property (p_arb) else $error("arbitration stuff error changed count");
property p_pas_ack;
    EV_TX_ERR && ERR_IS_ACK && ERR_PASSIVE && !EV_BIT_ERR_FLAG && !EV_VALID && !BUS_OFF |=> $stable(TEC_VALUE);
endproperty
a_pas_ack: assert property (p_pas_ack) else $error("passive ack error raised count");
property p_passive; (TEC_VALUE > 8'h7f || REC_VALUE > 8'h7f) [*2] |=> ERR_PASSIVE; endproperty
a_passive: assert property (p_passive) else $error("not passive above limit");
property p_active; (TEC_VALUE < 8'h80 && REC_VALUE < 8'h80 && !BUS_OFF) [*2] |=> !ERR_PASSIVE; endproperty
a_active: assert property (p_active) else $error("still passive below limit");
property p_drv; BUS_OFF && $past(BUS_OFF) |-> !CAN_TX_OE && CAN_TX; endproperty
a_drv: assert property (p_drv) else $error("driver active in bus off");
property p_ovf; EV_BIT_ERR_FLAG && !BUS_OFF && TEC_VALUE > 8'hf7 |=> BUS_OFF && TEC_VALUE == 8'hff; endproperty
a_ovf: assert property (p_ovf) else $error("overflow did not enter bus off");
property p_clear; REC_CLEAR |-> !BUS_OFF && TEC_VALUE == 8'h00; endproperty
a_clear: assert property (p_clear) else $error("counts not cleared on recovery");
property p_txpt; SAMPLE_PT |-> !TX_POINT ##[1:1000] TX_POINT; endproperty
a_txpt: assert property (p_txpt) else $error("no transmit point after sample");
property p_rx_hold; !SAMPLE_PT |-> $stable(RX_BIT); endproperty
a_rx_hold: assert property (p_rx_hold) else $error("sampled bit moved off sample point");
endmodule
bind cbs_top cbs_checker chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .WB_ACK_O(WB_ACK_O), .CAN_TX(CAN_TX),
    .CAN_TX_OE(CAN_TX_OE), .EV_BIT_ERR_FLAG(EV_BIT_ERR_FLAG), .EV_TX_ERR(EV_TX_ERR), .ERR_IS_ACK(ERR_IS_ACK),
    .ERR_STUFF_ARB(ERR_STUFF_ARB), .EV_VALID(EV_VALID), .REC_VALUE(REC_VALUE), .SAMPLE_PT(SAMPLE_PT),
    .RX_BIT(RX_BIT), .TX_POINT(TX_POINT), .TEC_VALUE(TEC_VALUE), .ERR_PASSIVE(ERR_PASSIVE),
    .BUS_OFF(BUS_OFF), .REC_CLEAR(REC_CLEAR));

// [tb/cbs_node.sv]
// Other bus node that pulls the shared line dominant on request
`timescale 1ns/1ns
module cbs_node (
    input  wire  clk,
    output logic line
);
initial line = 1'b1;
// Dominant for n clocks, then released to recessive
task drive(input int n);
    @(posedge clk);
    line <= 1'b0;
    repeat (n) @(posedge clk);
    line <= 1'b1;
endtask
endmodule

// [tb/can_error_count_bit_sync_tb.sv]
// Self-checking bench for the CAN error counter and bit timing block
`timescale 1ns/1ns
module can_error_count_bit_sync_tb;
logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ebit = 0, etx = 0, eack = 0, earb = 0, eval = 0, fend = 0;
logic [7:0] adr = 0, receive_error_count = 0;
logic idle = 1, frx = 0;
logic [3:0] sel = 0;
logic [31:0] wdat = 0, q;
wire [31:0] rdat;
wire [7:0] transmit_error_count;
wire ack, tx, oe, smp, rxb, txp, pas, boff, rclr, node_line;
wire can_rx = node_line & (oe ? tx : 1'b1);
int error_cnt = 0, checks = 0, a, b, n;
logic [12:0] rows [5] = '{{5'b10000, 8'd8}, {5'b01000, 8'd16}, {5'b01010, 8'd16}, {5'b00001, 8'd15},
                          {5'b01100, 8'd23}};
always #2 clk = ~clk;
cbs_node node (.clk(clk), .line(node_line));
cbs_top dut (.CLK_SYS(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CAN_RX(can_rx), .CAN_TX(tx),
    .CAN_TX_OE(oe), .TX_BIT(1'b1), .BUS_IDLE(idle), .FRAME_RX(frx), .EV_BIT_ERR_FLAG(ebit), .EV_TX_ERR(etx),
    .ERR_IS_ACK(eack), .ERR_STUFF_ARB(earb), .PFLAG_DOM_SEEN(1'b0), .EV_FLAG_END_ACT(fend),
    .EV_FLAG_END_PAS(1'b0), .EV_VALID(eval), .REC_VALUE(receive_error_count), .SAMPLE_PT(smp), .RX_BIT(rxb), .TX_POINT(txp),
    .TEC_VALUE(transmit_error_count), .ERR_PASSIVE(pas), .BUS_OFF(boff), .REC_CLEAR(rclr));
task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
        error_cnt++;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
endtask
task test_done;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= ad; wdat <= d; sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0; sel <= 4'h0;
endtask
task ev(input logic [4:0] f);
    @(posedge clk);
    {ebit, etx, eack, earb, eval} <= f;
    @(posedge clk);
    {ebit, etx, eack, earb, eval} <= 5'b0;
    repeat (3) @(posedge clk);
endtask
// Cycles from a sample point to the transmit point and to the next sample
task measure;
    n = 0;
    do @(posedge clk); while (smp !== 1'b1 && ++n < 200);
    a = 0; b = 0;
    do begin
        @(posedge clk);
        b++;
        if (txp === 1'b1) a = b;
    end while (smp !== 1'b1 && b < 200);
endtask
initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk(transmit_error_count, 0);
    chk({oe, tx, boff, pas}, 4'b0100);
    wb(0, 8'h00, 0);
    chk(q, 32'h00033100);
    wb(1, 8'h08, 32'hffffffff);
    wb(0, 8'h08, 0);
    chk(q, 0);
    $display("reset and registers done");
    foreach (rows[i]) begin
        ev(rows[i][12:8]);
        chk(transmit_error_count, rows[i][7:0]);
    end
    // Aligned to a transmit point so the segment field reads propagation
    do @(posedge clk); while (txp !== 1'b1);
    wb(0, 8'h04, 0);
    chk(q, 32'h00040017);
    $display("event rows done");
    measure; measure;
    chk(a, 4);
    chk(b, 11);
    wb(1, 8'h00, 32'h00007701);
    measure; measure;
    chk(a, 2);
    chk(b, 36);
    wb(1, 8'h00, 32'h00033100);
    measure;
    idle <= 0; frx <= 1;
    // Edge in phase 1 stretches it by four quanta
    repeat (3) @(posedge clk);
    node.drive(2);
    measure;
    chk(n, 8);
    chk(b, 11);
    // Edge early in phase 2 cuts it to the floor
    repeat (7) @(posedge clk);
    node.drive(2);
    measure;
    chk(a, 2);
    chk(b, 9);
    // Second edge in the same bit is ignored
    repeat (3) @(posedge clk);
    node.drive(2);
    repeat (5) @(posedge clk);
    node.drive(2);
    measure;
    chk(a, 4);
    chk(b, 11);
    idle <= 1; frx <= 0;
    $display("bit timing done");
    @(posedge clk) fend <= 1;
    @(posedge clk) fend <= 0;
    node.drive(159);
    repeat (40) @(posedge clk);
    chk(transmit_error_count, 31);
    $display("dominant run done");
    @(posedge clk) receive_error_count <= 8'h80;
    repeat (4) @(posedge clk);
    chk(pas, 1);
    @(posedge clk) receive_error_count <= 8'h00;
    repeat (4) @(posedge clk);
    chk(pas, 0);
    repeat (13) ev(5'b10000);
    chk({pas, transmit_error_count}, {1'b1, 8'd135});
    ev(5'b01100);
    chk(transmit_error_count, 135);
    repeat (16) ev(5'b10000);
    chk({boff, oe, transmit_error_count}, {2'b10, 8'hff});
    ev(5'b10000);
    chk(transmit_error_count, 8'hff);
    $display("passive and bus off done");
    do @(posedge clk); while (rclr !== 1'b1);
    repeat (3) @(posedge clk);
    chk({boff, transmit_error_count}, 9'h000);
    ev(5'b00001);
    chk(transmit_error_count, 0);
    $display("recovery done");
    test_done;
end
initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    test_done;
end
endmodule
